// >>> core/ssf_map.svh
`ifndef SSF_MAP_SVH
`define SSF_MAP_SVH
// ---------------------------------------------
// Register offsets
// ---------------------------------------------
`define SSF_OFF_CTRL 4'h0
`define SSF_OFF_STAT 4'h4
`define SSF_OFF_DATA 4'h8
// ---------------------------------------------
// Control fields
// ---------------------------------------------
`define SSF_CTL_EN 0
`define SSF_CTL_FIFO 1
`define SSF_CTL_FRM 2
`define SSF_CTL_IGNOV 3
`define SSF_CTL_OVEV 4
`define SSF_CTRL_RST 5'h00
// ---------------------------------------------
// Status fields
// ---------------------------------------------
`define SSF_ST_RXCNT 24
`define SSF_ST_TXCNT 16
`define SSF_ST_FRAME_ERROR_FLAG 12
`define SSF_ST_BUSY 11
`define SSF_ST_TUR 8
`define SSF_ST_SHIFT_REG_EMPTY 7
`define SSF_ST_ROV 6
`define SSF_ST_RBE 5
`define SSF_ST_TBE 3
`define SSF_ST_TBF 1
`define SSF_ST_RBF 0
`define SSF_ST_UNUSED 32'hE0E0_E614
`define SSF_LAST_BIT 3'h7
`endif

// >>> core/ssf_pkg.sv
package ssf_pkg;
   typedef logic [3:0] ssf_addr_t;
   typedef logic [7:0] ssf_byte_t;
   typedef logic [31:0] ssf_word_t;
   typedef enum logic [1:0]
   {
      SSF_IDLE = 2'b00,
      SSF_ACTIVE = 2'b01,
      SSF_HALT = 2'b10
   } ssf_state_t;
endpackage : ssf_pkg

// >>> core/ssf_status_core.sv
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "ssf_map.svh"
module ssf_status_core
(
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RSTN,
   // Register port
   input wire ssf_pkg::ssf_addr_t ADDR,
   input wire ssf_pkg::ssf_word_t WDATA,
   input wire logic WR,
   input wire logic RD,
   output ssf_pkg::ssf_word_t RDATA,
   // Serial link
   input wire logic SCK,
   input wire logic SS_N,
   input wire logic SDI,
   output logic SDO,
   output logic SDO_OE,
   // Error event
   output logic ERR_EVENT
);
   import ssf_pkg::*;

   // ---------------------------------------------
   // Control register
   // ---------------------------------------------
   logic [4:0] ctrl_r;
   logic en, fifo_mode, framed, ign_ov, ov_ev;
   assign en = ctrl_r[`SSF_CTL_EN];
   assign fifo_mode = ctrl_r[`SSF_CTL_FIFO];
   assign framed = ctrl_r[`SSF_CTL_FRM];
   assign ign_ov = ctrl_r[`SSF_CTL_IGNOV];
   assign ov_ev = ctrl_r[`SSF_CTL_OVEV];

   always_ff @(posedge CLOCK or negedge RSTN)
   begin
      if (!RSTN)
         ctrl_r <= `SSF_CTRL_RST;
      else if (WR && ADDR == `SSF_OFF_CTRL)
         ctrl_r <= WDATA[4:0];
   end

   // ---------------------------------------------
   // Pin synchronisers and edges
   // ---------------------------------------------
   logic [2:0] sck_s1_r, sck_s2_r;
   logic sck_d_r, ss_d_r;
   always_ff @(posedge CLOCK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         // Idle pin levels: select high, clock low
         sck_s1_r <= 3'h5;
         sck_s2_r <= 3'h5;
         sck_d_r <= 1'b0;
         ss_d_r <= 1'b1;
      end
      else
      begin
         sck_s1_r <= {SS_N, SDI, 1'b0} | {2'h0, SCK} ^ 3'h1;
         sck_s2_r <= sck_s1_r;
         sck_d_r <= ~sck_s2_r[0];
         ss_d_r <= sck_s2_r[2];
      end
   end
   logic sck_q, ss_q, sdi_q, sck_rise, sck_fall, ss_fall, ss_rise;
   assign sck_q = ~sck_s2_r[0];
   assign sdi_q = sck_s2_r[1];
   assign ss_q = sck_s2_r[2];
   assign sck_rise = sck_q && !sck_d_r;
   assign sck_fall = !sck_q && sck_d_r;
   assign ss_fall = !ss_q && ss_d_r;
   assign ss_rise = ss_q && !ss_d_r;

   // ---------------------------------------------
   // Buffers and pointers
   // ---------------------------------------------
   ssf_byte_t tx_mem [16];
   ssf_byte_t rx_mem [16];
   logic [3:0] tx_wptr_r, tx_rptr_r, rx_wptr_r, rx_rptr_r;
   logic tx_empty, tx_full, rx_empty, rx_full;
   assign tx_empty = tx_wptr_r == tx_rptr_r;
   assign rx_empty = rx_wptr_r == rx_rptr_r;
   // Standard mode keeps one word, FIFO mode keeps fifteen
   assign tx_full = fifo_mode ? 4'(tx_wptr_r + 4'h1) == tx_rptr_r : !tx_empty;
   assign rx_full = fifo_mode ? 4'(rx_wptr_r + 4'h1) == rx_rptr_r : !rx_empty;

   ssf_state_t st_r;
   logic [2:0] bit_cnt_r;
   ssf_byte_t tx_sh_r, rx_sh_r;
   logic sr_loaded_r, rov_r, tur_r, frm_r;
   logic tx_push, rx_pop, load, word_done, ovf, stat_wr;
   assign tx_push = en && WR && ADDR == `SSF_OFF_DATA && !tx_full;
   assign rx_pop = en && RD && ADDR == `SSF_OFF_DATA && !rx_empty;
   assign load = st_r == SSF_ACTIVE && !sr_loaded_r && !tx_empty && bit_cnt_r == 3'h0 && !ss_rise;
   assign word_done = st_r == SSF_ACTIVE && sck_rise && bit_cnt_r == `SSF_LAST_BIT;
   assign ovf = word_done && rx_full;
   assign stat_wr = WR && ADDR == `SSF_OFF_STAT;

   always_ff @(posedge CLOCK)
   begin
      if (tx_push)
         tx_mem[tx_wptr_r] <= WDATA[7:0];
      if (word_done && !rx_full)
         rx_mem[rx_wptr_r] <= {rx_sh_r[6:0], sdi_q};
   end

   always_ff @(posedge CLOCK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         tx_wptr_r <= 4'h0;
         tx_rptr_r <= 4'h0;
         rx_wptr_r <= 4'h0;
         rx_rptr_r <= 4'h0;
      end
      else if (!en)
      begin
         tx_wptr_r <= 4'h0;
         tx_rptr_r <= 4'h0;
         rx_wptr_r <= 4'h0;
         rx_rptr_r <= 4'h0;
      end
      else
      begin
         if (tx_push)
            tx_wptr_r <= 4'(tx_wptr_r + 4'h1);
         if (load)
            tx_rptr_r <= 4'(tx_rptr_r + 4'h1);
         if (word_done && !rx_full)
            rx_wptr_r <= 4'(rx_wptr_r + 4'h1);
         if (rx_pop)
            rx_rptr_r <= 4'(rx_rptr_r + 4'h1);
      end
   end

   // ---------------------------------------------
   // Shift engine, mode 0 slave
   // ---------------------------------------------
   always_ff @(posedge CLOCK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         st_r <= SSF_IDLE;
         bit_cnt_r <= 3'h0;
         tx_sh_r <= 8'h00;
         rx_sh_r <= 8'h00;
         sr_loaded_r <= 1'b0;
      end
      else if (!en)
      begin
         st_r <= SSF_IDLE;
         bit_cnt_r <= 3'h0;
         tx_sh_r <= 8'h00;
         sr_loaded_r <= 1'b0;
      end
      else
      begin
         case (st_r)
            SSF_IDLE:
            begin
               if (ss_fall)
                  st_r <= SSF_ACTIVE;
               bit_cnt_r <= 3'h0;
            end
            SSF_ACTIVE:
            begin
               if (ss_rise)
               begin
                  st_r <= SSF_IDLE;
                  bit_cnt_r <= 3'h0;
                  // Partial word dropped, untouched word kept for next frame
                  if (bit_cnt_r != 3'h0)
                     sr_loaded_r <= 1'b0;
               end
               else if (load)
               begin
                  tx_sh_r <= tx_mem[tx_rptr_r];
                  sr_loaded_r <= 1'b1;
               end
               else if (sck_rise)
               begin
                  rx_sh_r <= {rx_sh_r[6:0], sdi_q};
                  bit_cnt_r <= 3'(bit_cnt_r + 3'h1);
                  if (word_done)
                     sr_loaded_r <= 1'b0;
                  if (ovf && !ign_ov)
                     st_r <= SSF_HALT;
               end
               // Fall after a word boundary keeps the freshly loaded MSB
               else if (sck_fall && bit_cnt_r != 3'h0)
                  tx_sh_r <= {tx_sh_r[6:0], 1'b0};
            end
            SSF_HALT:
               sr_loaded_r <= 1'b0;
            default:
               st_r <= SSF_IDLE;
         endcase
      end
   end
   assign SDO = tx_sh_r[7];
   assign SDO_OE = st_r == SSF_ACTIVE;

   // ---------------------------------------------
   // Sticky flags, set wins over clear, and one-cycle error event pulse
   // ---------------------------------------------
   logic frm_set, tur_set;
   assign frm_set = framed && st_r == SSF_ACTIVE && ss_rise && bit_cnt_r != 3'h0;
   assign tur_set = framed && st_r == SSF_IDLE && ss_fall && tx_empty;
   always_ff @(posedge CLOCK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         rov_r <= 1'b0;
         tur_r <= 1'b0;
         frm_r <= 1'b0;
         ERR_EVENT <= 1'b0;
      end
      else if (!en)
      begin
         rov_r <= 1'b0;
         tur_r <= 1'b0;
         frm_r <= 1'b0;
         ERR_EVENT <= 1'b0;
      end
      else
      begin
         rov_r <= ovf || (rov_r && !(stat_wr && !WDATA[`SSF_ST_ROV]));
         tur_r <= tur_set || (tur_r && !(stat_wr && !WDATA[`SSF_ST_TUR]));
         frm_r <= frm_set || (frm_r && !(stat_wr && !WDATA[`SSF_ST_FRAME_ERROR_FLAG]));
         ERR_EVENT <= ovf && ov_ev;
      end
   end

   // ---------------------------------------------
   // Status word and read port
   // ---------------------------------------------
   ssf_word_t stat;
   always_comb
   begin
      stat = 32'h0000_0000;
      stat[`SSF_ST_RXCNT +: 5] = fifo_mode ? {1'b0, 4'(rx_wptr_r - rx_rptr_r)} : 5'h00;
      stat[`SSF_ST_TXCNT +: 5] = fifo_mode ? {1'b0, 4'(tx_wptr_r - tx_rptr_r)} : 5'h00;
      stat[`SSF_ST_FRAME_ERROR_FLAG] = frm_r;
      stat[`SSF_ST_BUSY] = st_r == SSF_ACTIVE || sr_loaded_r;
      stat[`SSF_ST_TUR] = tur_r;
      stat[`SSF_ST_SHIFT_REG_EMPTY] = fifo_mode && !sr_loaded_r;
      stat[`SSF_ST_ROV] = rov_r;
      stat[`SSF_ST_RBE] = fifo_mode && rx_empty;
      stat[`SSF_ST_TBE] = tx_empty;
      stat[`SSF_ST_TBF] = tx_full;
      stat[`SSF_ST_RBF] = rx_full;
   end

   always_ff @(posedge CLOCK or negedge RSTN)
   begin
      if (!RSTN)
         RDATA <= 32'h0000_0000;
      else if (RD)
         case (ADDR)
            `SSF_OFF_CTRL: RDATA <= {27'h000_0000, ctrl_r};
            `SSF_OFF_STAT: RDATA <= stat;
            `SSF_OFF_DATA: RDATA <= {24'h00_0000, rx_mem[rx_rptr_r]};
            default: RDATA <= 32'h0000_0000;
         endcase
      else
         RDATA <= 32'h0000_0000;
   end

   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RSTN);

   AST_UNUSED_ZERO: assert property ($past(RD) && $past(ADDR) == `SSF_OFF_STAT |->
      (RDATA & `SSF_ST_UNUSED) == 32'h0000_0000) else $error("unused status bit set");
   AST_RXCNT: assert property (RD && ADDR == `SSF_OFF_STAT && fifo_mode && !WR |=>
      RDATA[28:24] == {1'b0, 4'($past(rx_wptr_r) - $past(rx_rptr_r))}) else $error("rx count wrong");
   AST_ROV_SET: assert property (en && ovf |=> rov_r && $stable(rx_wptr_r))
      else $error("overflow not flagged or word kept");
   AST_HALT: assert property (en && ovf && !ign_ov |=> st_r == SSF_HALT [*2])
      else $error("overflow did not halt link");
   AST_NO_EVENT: assert property (ovf && !ov_ev |=> !ERR_EVENT) else $error("event while masked");
   AST_EVENT: assert property (en && ovf && ov_ev |=> ERR_EVENT) else $error("missing error event");
   AST_DISABLE: assert property (!en |=> !rov_r && !tur_r && !frm_r && tx_empty)
      else $error("flags kept while disabled");
   AST_TBF_STD: assert property (en && !fifo_mode && tx_push |=> tx_full && !stat[`SSF_ST_TBE])
      else $error("standard tx full not set");
   AST_RBF_CLR: assert property (en && !fifo_mode && rx_pop && !word_done |=> !rx_full)
      else $error("standard rx full not cleared");
   AST_BUSY: assert property (st_r == SSF_ACTIVE |-> stat[`SSF_ST_BUSY]) else $error("busy low in frame");
   AST_FRAME_ERROR_FLAG: assert property (en && frm_set |=> frm_r) else $error("frame error lost");
   AST_TUR: assert property (en && tur_set |=> tur_r) else $error("underrun lost");
   AST_RBF_FIFO: assert property (fifo_mode && rx_wptr_r == 4'(rx_rptr_r - 4'h1) |-> stat[`SSF_ST_RBF])
      else $error("fifo rx full missing");

   COV_OVERFLOW: cover property (en && ovf);
   COV_FRAME_ERROR_FLAG: cover property (en && frm_set);
   COV_UNDERRUN: cover property (en && tur_set);
   COV_TX_FULL: cover property (fifo_mode && tx_full);
endmodule : ssf_status_core

// >>> testbench/ssf_master_model.sv
`timescale 1ns/1ps
module ssf_master_model
(
   // Clock
   input wire logic CLOCK,
   // Serial link
   output logic SCK,
   output logic SS_N,
   output logic SDI,
   input wire logic SDO,
   input wire logic SDO_OE
);
   import ssf_pkg::*;
   logic seen;
   initial
   begin
      SCK = 1'b0;
      SS_N = 1'b1;
      SDI = 1'b0;
      seen = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n)
      begin
         @(posedge CLOCK);
         if (SDO_OE === 1'b1)
            seen = 1'b1;
      end
   endtask : tick
   // ----------------------------------------
   // Mode 0 frame, MSB first, 160 ns link clock
   // ----------------------------------------
   task automatic frame(input ssf_byte_t tx, input int nbits, output ssf_byte_t rx);
      seen = 1'b0;
      rx = '0;
      @(posedge CLOCK);
      SS_N <= 1'b0;
      tick(10);
      for (int i = 0; i < nbits; i++)
      begin
         SDI <= tx[7 - i];
         tick(10);
         SCK <= 1'b1;
         rx = {rx[6:0], SDO};
         tick(10);
         SCK <= 1'b0;
      end
      tick(10);
      SS_N <= 1'b1;
      // Released line shows no stale bit
      SDI <= ~SDI;
      tick(10);
   endtask : frame
endmodule : ssf_master_model

// >>> testbench/ssf_status_core_tb.sv
`timescale 1ns/1ps
`include "ssf_map.svh"
module ssf_status_core_tb;
   import ssf_pkg::*;
   logic CLOCK, RSTN, WR, RD, SCK, SS_N, SDI, SDO, SDO_OE, ERR_EVENT;
   ssf_addr_t ADDR;
   ssf_word_t WDATA, RDATA, d;
   ssf_byte_t rx;
   int n_fail = 0;
   int cmp_count = 0;
   int n_ev = 0;
   ssf_status_core ssf_status_core_inst (.CLOCK(CLOCK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
      .RD(RD), .RDATA(RDATA), .SCK(SCK), .SS_N(SS_N), .SDI(SDI), .SDO(SDO), .SDO_OE(SDO_OE),
      .ERR_EVENT(ERR_EVENT));
   ssf_master_model ssf_master_model_inst (.CLOCK(CLOCK), .SCK(SCK), .SS_N(SS_N), .SDI(SDI), .SDO(SDO),
      .SDO_OE(SDO_OE));
   initial
   begin
      CLOCK = 1'b0;
      forever #4 CLOCK = ~CLOCK;
   end
   always @(posedge CLOCK)
      if (ERR_EVENT === 1'b1)
         n_ev++;
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_of_test
   task automatic chk(input string name, input ssf_word_t exp, input ssf_word_t got);
      cmp_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic wr(input ssf_addr_t a, input ssf_word_t v);
      @(posedge CLOCK);
      WR <= 1'b1;
      ADDR <= a;
      WDATA <= v;
      @(posedge CLOCK);
      WR <= 1'b0;
   endtask : wr
   task automatic rd(input ssf_addr_t a, output ssf_word_t v);
      @(posedge CLOCK);
      RD <= 1'b1;
      ADDR <= a;
      @(posedge CLOCK);
      RD <= 1'b0;
      #1 v = RDATA;
   endtask : rd
   task automatic st(input ssf_word_t mask, input ssf_word_t exp);
      ssf_word_t v;
      rd(`SSF_OFF_STAT, v);
      chk("status", exp, v & mask);
   endtask : st
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset;
      st(32'hFFFF_FFFF, 32'h0000_0008);
      rd(4'hC, d);
      chk("unmapped", 32'h0000_0000, d);
   endtask : t_reset
   task automatic t_std;
      wr(`SSF_OFF_CTRL, 32'h0000_0001);
      wr(`SSF_OFF_DATA, 32'h0000_00A5);
      st(32'h0000_000B, 32'h0000_0002);
      fork
         ssf_master_model_inst.frame(8'h3C, 8, rx);
         begin
            repeat (90) @(posedge CLOCK);
            st(32'h0000_0800, 32'h0000_0800);
         end
      join
      chk("sdo_word", 32'h0000_00A5, {24'h00_0000, rx});
      st(32'h0000_080B, 32'h0000_0009);
      rd(`SSF_OFF_DATA, d);
      chk("rx_data", 32'h0000_003C, d & 32'h0000_00FF);
      st(32'h0000_0001, 32'h0000_0000);
      wr(`SSF_OFF_CTRL, 32'h0000_0000);
   endtask : t_std
   task automatic t_ovf;
      wr(`SSF_OFF_CTRL, 32'h0000_0011);
      ssf_master_model_inst.frame(8'h11, 8, rx);
      ssf_master_model_inst.frame(8'h22, 8, rx);
      st(32'h0000_0041, 32'h0000_0041);
      chk("err_events", 32'h0000_0001, 32'(n_ev));
      ssf_master_model_inst.frame(8'h33, 8, rx);
      chk("halt_oe", 32'h0000_0000, {31'h0, ssf_master_model_inst.seen});
      rd(`SSF_OFF_DATA, d);
      chk("kept_word", 32'h0000_0011, d & 32'h0000_00FF);
      wr(`SSF_OFF_CTRL, 32'h0000_0000);
      st(32'hFFFF_FFFF, 32'h0000_0008);
   endtask : t_ovf
   task automatic t_ovf_ign;
      int ev0;
      ev0 = n_ev;
      wr(`SSF_OFF_CTRL, 32'h0000_0009);
      ssf_master_model_inst.frame(8'h44, 8, rx);
      ssf_master_model_inst.frame(8'h55, 8, rx);
      ssf_master_model_inst.frame(8'h66, 8, rx);
      chk("ign_oe", 32'h0000_0001, {31'h0, ssf_master_model_inst.seen});
      chk("masked_events", 32'(ev0), 32'(n_ev));
      st(32'h0000_0841, 32'h0000_0041);
      rd(`SSF_OFF_DATA, d);
      chk("ign_kept", 32'h0000_0044, d & 32'h0000_00FF);
      wr(`SSF_OFF_CTRL, 32'h0000_0000);
   endtask : t_ovf_ign
   task automatic t_fifo;
      wr(`SSF_OFF_CTRL, 32'h0000_0003);
      for (int i = 0; i < 3; i++)
         wr(`SSF_OFF_DATA, 32'h0000_0040 + 32'(i));
      st(32'h001F_00A2, 32'h0003_00A0);
      for (int i = 3; i < 16; i++)
         wr(`SSF_OFF_DATA, 32'h0000_0040 + 32'(i));
      st(32'h001F_0002, 32'h000F_0002);
      ssf_master_model_inst.frame(8'hC0, 8, rx);
      chk("fifo_sdo", 32'h0000_0040, {24'h00_0000, rx});
      // Next word waits in the shifter between frames
      st(32'h0000_0880, 32'h0000_0800);
      for (int i = 1; i < 15; i++)
      begin
         ssf_master_model_inst.frame(8'hC0 + 8'(i), 8, rx);
         chk("fifo_sdo", 32'h0000_0040 + 32'(i), {24'h00_0000, rx});
      end
      st(32'h1F00_00A1, 32'h0F00_0081);
      rd(`SSF_OFF_DATA, d);
      chk("fifo_rx", 32'h0000_00C0, d & 32'h0000_00FF);
      st(32'h1F00_0021, 32'h0E00_0000);
      wr(`SSF_OFF_CTRL, 32'h0000_0000);
   endtask : t_fifo
   task automatic t_frm;
      wr(`SSF_OFF_CTRL, 32'h0000_0005);
      ssf_master_model_inst.frame(8'h5A, 8, rx);
      ssf_master_model_inst.frame(8'h5A, 4, rx);
      st(32'h0000_1100, 32'h0000_1100);
      wr(`SSF_OFF_STAT, 32'hFFFF_FFFF);
      st(`SSF_ST_UNUSED | 32'h0000_1100, 32'h0000_1100);
      // Flags handled before clearing
      wr(`SSF_OFF_STAT, 32'h0000_0000);
      st(32'h0000_1100, 32'h0000_0000);
      wr(`SSF_OFF_CTRL, 32'h0000_0000);
   endtask : t_frm
   initial
   begin
      RSTN = 1'b0;
      WR = 1'b0;
      RD = 1'b0;
      ADDR = '0;
      WDATA = '0;
      repeat (6) @(posedge CLOCK);
      RSTN <= 1'b1;
      t_reset;
      t_std;
      t_ovf;
      t_ovf_ign;
      t_fifo;
      t_frm;
      end_of_test;
   end
   initial
   begin
      repeat (20000) @(posedge CLOCK);
      n_fail++;
      end_of_test;
   end
endmodule : ssf_status_core_tb
